/* File: shared/qmcs_pkg.sv */
package qmcs_pkg;

   // =========================================================
   // register selects, numbered locally for this access port
   localparam logic [3:0] SEL_MOD_COND  = 4'h0;
   localparam logic [3:0] SEL_MOD_FALL  = 4'h1;
   localparam logic [3:0] SEL_MOD_RISE  = 4'h2;
   localparam logic [3:0] SEL_MOD_EVENT = 4'h3;
   localparam logic [3:0] SEL_MOD_MASK  = 4'h4;
   localparam logic [3:0] SEL_CAL_COND  = 4'h5;
   localparam logic [3:0] SEL_CAL_FALL  = 4'h6;
   localparam logic [3:0] SEL_CAL_RISE  = 4'h7;
   localparam logic [3:0] SEL_CAL_EVENT = 4'h8;
   localparam logic [3:0] SEL_CAL_MASK  = 4'h9;

   // =========================================================
   // field layout
   localparam int REG_WIDTH        = 16;
   localparam int MOD_USED_BITS    = 5;
   localparam int CAL_USED_BITS    = 2;
   localparam int MOD_UNDER1_BIT   = 0;
   localparam int MOD_OVER1_BIT    = 1;
   localparam int MOD_UNDER2_BIT   = 2;
   localparam int MOD_OVER2_BIT    = 3;
   localparam int MOD_UNCAL_BIT    = 4;
   localparam int CAL_DCZERO_BIT   = 0;
   localparam int CAL_IQ_BIT       = 1;
   localparam int PARENT_MOD_BIT   = 7;
   localparam int PARENT_CAL_BIT   = 8;

   // =========================================================
   // reset values
   localparam logic [15:0] FILTER_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET   = 16'h0000;
   localparam logic [15:0] EVENT_RESET  = 16'h0000;

   // raw status levels from the analog and calibration logic
   typedef struct packed {
      logic ext1Under;
      logic ext1Over;
      logic ext2Under;
      logic ext2Over;
      logic modUncal;
      logic dcFreqPhaseModZeroFail;
      logic iqCalFail;
   } qmcs_status_t;

   // register access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  sel;
      logic [15:0] wdata;
   } qmcs_req_t;

endpackage

/* File: design/qmcs_group.sv */
`timescale 1ns/1ps
// one status group: filters, sticky events, mask and summary
module qmcs_group
#(
   parameter int WIDTH = 16,
   parameter int USED  = 5
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // condition input (already synchronised)
   input  wire logic [WIDTH-1:0] cond,
   // register writes and event read
   input  wire logic             wrRise,
   input  wire logic             wrFall,
   input  wire logic             wrMask,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic             rdEvent,
   // register contents and summary
   output logic      [WIDTH-1:0] riseFilter,
   output logic      [WIDTH-1:0] fallFilter,
   output logic      [WIDTH-1:0] eventBits,
   output logic      [WIDTH-1:0] eventMask,
   output logic                  summary
);
   import qmcs_pkg::*;

   // a group must own at least one bit and no more than it holds
   if (USED < 1 || USED > WIDTH)
   begin
      $error("qmcs_group: USED out of range");
   end

   localparam logic [WIDTH-1:0] USED_MASK =
      WIDTH'((64'h1 << USED) - 64'h1);

   logic [WIDTH-1:0] riseReg, riseNext;
   logic [WIDTH-1:0] fallReg, fallNext;
   logic [WIDTH-1:0] maskReg, maskNext;
   logic [WIDTH-1:0] eventReg, eventNext;
   logic [WIDTH-1:0] prevReg, prevNext;
   logic [WIDTH-1:0] hits;

   // =========================================================
   // next-state
   always_comb
   begin
      riseNext  = wrRise ? wdata : riseReg;
      fallNext  = wrFall ? wdata : fallReg;
      maskNext  = wrMask ? wdata : maskReg;
      prevNext  = cond & USED_MASK;
      // bits above USED never raise an event, whatever the filters hold
      hits      = ((cond & ~prevReg & riseReg)
                | (~cond & prevReg & fallReg)) & USED_MASK;
      // set wins over the read-clear so no change is lost
      eventNext = (rdEvent ? '0 : eventReg) | hits;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         riseReg  <= FILTER_RESET;
         fallReg  <= FILTER_RESET;
         maskReg  <= MASK_RESET;
         eventReg <= EVENT_RESET;
         prevReg  <= '0;
      end
      else
      begin
         riseReg  <= riseNext;
         fallReg  <= fallNext;
         maskReg  <= maskNext;
         eventReg <= eventNext;
         prevReg  <= prevNext;
      end
   end

   assign riseFilter = riseReg;
   assign fallFilter = fallReg;
   assign eventBits  = eventReg;
   assign eventMask  = maskReg;
   assign summary    = |(eventReg & maskReg);
endmodule

/* File: design/qmcs_top.sv */
`timescale 1ns/1ps
module qmcs_top
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // raw status levels, asynchronous to clk
   input  wire qmcs_pkg::qmcs_status_t status,
   // register access port
   input  wire qmcs_pkg::qmcs_req_t  req,
   output logic [15:0]               rdata,
   output logic                      rdValid,
   // summary bits into the parent questionable register
   output logic [15:0]               parentSummary
);
   import qmcs_pkg::*;

   // =========================================================
   // synchronisers
   // levels have no timing relation to clk: only stage B is ever read
   qmcs_status_t syncAReg, syncANext;
   qmcs_status_t syncBReg, syncBNext;

   always_comb
   begin
      syncANext = status;
      syncBNext = syncAReg;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncAReg <= '0;
         syncBReg <= '0;
      end
      else
      begin
         syncAReg <= syncANext;
         syncBReg <= syncBNext;
      end
   end

   // =========================================================
   // condition registers
   logic [REG_WIDTH-1:0] modCond, calCond;

   always_comb
   begin
      modCond = '0;
      modCond[MOD_UNDER1_BIT] = syncBReg.ext1Under;
      modCond[MOD_OVER1_BIT]  = syncBReg.ext1Over;
      modCond[MOD_UNDER2_BIT] = syncBReg.ext2Under;
      modCond[MOD_OVER2_BIT]  = syncBReg.ext2Over;
      modCond[MOD_UNCAL_BIT]  = syncBReg.modUncal;
      calCond = '0;
      calCond[CAL_DCZERO_BIT] = syncBReg.dcFreqPhaseModZeroFail;
      calCond[CAL_IQ_BIT]     = syncBReg.iqCalFail;
   end

   // =========================================================
   // access decode
   function automatic logic hit(input qmcs_req_t r, input logic [3:0] s);
      hit = r.sel == s;
   endfunction

   logic rdModEvent, rdCalEvent;
   assign rdModEvent = req.rd && hit(req, SEL_MOD_EVENT);
   assign rdCalEvent = req.rd && hit(req, SEL_CAL_EVENT);

   logic [REG_WIDTH-1:0] modRise, modFall, modEvent, modMask;
   logic [REG_WIDTH-1:0] calRise, calFall, calEvent, calMask;
   logic                 modSummary, calSummary;

   // condition selects take no write
   qmcs_group #(.WIDTH(REG_WIDTH), .USED(MOD_USED_BITS)) modGroup
   (
      .clk        (clk),
      .rst_n      (rst_n),
      .cond       (modCond),
      .wrRise     (req.wr && hit(req, SEL_MOD_RISE)),
      .wrFall     (req.wr && hit(req, SEL_MOD_FALL)),
      .wrMask     (req.wr && hit(req, SEL_MOD_MASK)),
      .wdata      (req.wdata),
      .rdEvent    (rdModEvent),
      .riseFilter (modRise),
      .fallFilter (modFall),
      .eventBits  (modEvent),
      .eventMask  (modMask),
      .summary    (modSummary)
   );

   qmcs_group #(.WIDTH(REG_WIDTH), .USED(CAL_USED_BITS)) calGroup
   (
      .clk        (clk),
      .rst_n      (rst_n),
      .cond       (calCond),
      .wrRise     (req.wr && hit(req, SEL_CAL_RISE)),
      .wrFall     (req.wr && hit(req, SEL_CAL_FALL)),
      .wrMask     (req.wr && hit(req, SEL_CAL_MASK)),
      .wdata      (req.wdata),
      .rdEvent    (rdCalEvent),
      .riseFilter (calRise),
      .fallFilter (calFall),
      .eventBits  (calEvent),
      .eventMask  (calMask),
      .summary    (calSummary)
   );

   // =========================================================
   // read data, registered; value is the binary weighted sum
   logic [15:0] rdataReg, rdataNext;
   logic        rdValidReg, rdValidNext;
   logic [15:0] sumReg, sumNext;

   always_comb
   begin
      rdValidNext = req.rd;
      rdataNext   = rdataReg;
      if (req.rd)
      begin
         unique case (req.sel)
            SEL_MOD_COND:  rdataNext = modCond;
            SEL_MOD_FALL:  rdataNext = modFall;
            SEL_MOD_RISE:  rdataNext = modRise;
            SEL_MOD_EVENT: rdataNext = modEvent;
            SEL_MOD_MASK:  rdataNext = modMask;
            SEL_CAL_COND:  rdataNext = calCond;
            SEL_CAL_FALL:  rdataNext = calFall;
            SEL_CAL_RISE:  rdataNext = calRise;
            SEL_CAL_EVENT: rdataNext = calEvent;
            SEL_CAL_MASK:  rdataNext = calMask;
            default:       rdataNext = 16'h0000;
         endcase
      end
      sumNext = 16'h0000;
      sumNext[PARENT_MOD_BIT] = modSummary;
      sumNext[PARENT_CAL_BIT] = calSummary;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdataReg   <= 16'h0000;
         rdValidReg <= 1'b0;
         sumReg     <= 16'h0000;
      end
      else
      begin
         rdataReg   <= rdataNext;
         rdValidReg <= rdValidNext;
         sumReg     <= sumNext;
      end
   end

   assign rdata         = rdataReg;
   assign rdValid       = rdValidReg;
   assign parentSummary = sumReg;
endmodule

/* File: verification/qmcs_monitor.sv */
`timescale 1ns/1ps
module qmcs_monitor
(
   // clock and reset
   input wire logic                   clk,
   input wire logic                   rst_n,
   // watched ports
   input wire qmcs_pkg::qmcs_status_t status,
   input wire qmcs_pkg::qmcs_req_t    req,
   input wire logic [15:0]            rdata,
   input wire logic                   rdValid,
   input wire logic [15:0]            parentSummary
);
   import qmcs_pkg::*;
   logic [4:0] modView;
   logic [1:0] calView;
   logic       rdMod;
   logic       rdCal;
   // =========================================================
   // expected condition bits straight from the levels
   assign modView = {status.modUncal, status.ext2Over, status.ext2Under,
                     status.ext1Over, status.ext1Under};
   assign calView = {status.iqCalFail, status.dcFreqPhaseModZeroFail};
   assign rdMod = req.rd && req.sel == SEL_MOD_COND;
   assign rdCal = req.rd && req.sel == SEL_CAL_COND;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // =========================================================
   // checks
   rd_answer_a: assert property (req.rd |=> rdValid)
      else $error("read not answered");
   rdata_hold_a: assert property (!req.rd |=> $stable(rdata))
      else $error("read data moved");
   parent_bits_a: assert property ((parentSummary & 16'hfe7f) == 0)
      else $error("stray parent bit");
   mod_unused_a: assert property (rdMod |=> rdata[15:5] == 0)
      else $error("unused modulation bit set");
   cal_unused_a: assert property (rdCal |=> rdata[15:2] == 0)
      else $error("unused calibration bit set");
   bad_sel_a: assert property (req.rd && req.sel > 9 |=> rdata == 0)
      else $error("unused select answered");
   mod_track_a: assert property (rdMod && $past(rst_n, 2)
      && $stable(status) && $past(status, 2) == status
      |=> rdata[4:0] == $past(modView))
      else $error("modulation condition wrong");
   cal_track_a: assert property (rdCal && $past(rst_n, 2)
      && $stable(status) && $past(status, 2) == status
      |=> rdata[1:0] == $past(calView))
      else $error("calibration condition wrong");
endmodule

/* File: verification/test_qmcs_top.sv */
`timescale 1ns/1ps
module test_qmcs_top;
   import qmcs_pkg::*;
   logic         clk;
   logic         rst_n;
   qmcs_status_t status;
   qmcs_req_t    req;
   logic [15:0]  rdata;
   logic         rdValid;
   logic [15:0]  parentSummary;
   int           failures;
   int           n_compared;

   qmcs_top i_qmcs_top (.clk(clk), .rst_n(rst_n), .status(status),
      .req(req), .rdata(rdata), .rdValid(rdValid),
      .parentSummary(parentSummary));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // =========================================================
   // shared steps
   task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
      n_compared++;
      if (s !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // the strobe stays up until the next request or idle replaces it
   task automatic op(logic w, logic [3:0] s, logic [15:0] d);
      req = '{w, !w, s, d};
      @(posedge clk);
      #1;
   endtask
   task automatic idle(int n);
      req = '0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd(logic [3:0] s, logic [15:0] e);
      op(1'b0, s, 16'h0000);
      chk("rdValid", 16'h0001, {15'h0, rdValid});
      chk("rdata", e, rdata);
   endtask
   // four edges cover the two-stage synchroniser, the event flop and the parent summary flop
   task automatic settle(logic [6:0] v);
      status = qmcs_status_t'(v);
      idle(4);
   endtask
   // =========================================================
   // scenarios
   task automatic t_regs();
      for (int i = 0; i < 16; i++)
         rd(4'(i), 16'h0000);
      for (int i = 0; i < 10; i++)
         op(1'b1, 4'(i), 16'ha5c3);
      for (int i = 0; i < 10; i++)
         rd(4'(i), (i inside {1, 2, 4, 6, 7, 9}) ? 16'ha5c3 : 16'h0);
      $display("t_regs done");
   endtask
   task automatic t_mod();
      op(1'b1, SEL_MOD_RISE, 16'hffff);
      op(1'b1, SEL_MOD_FALL, 16'h0000);
      op(1'b1, SEL_MOD_MASK, 16'h0010);
      for (int i = 0; i < 5; i++)
      begin
         settle(7'h40 >> i);
         rd(SEL_MOD_COND, 16'h0001 << i);
      end
      chk("summary", 16'h0080, parentSummary);
      rd(SEL_MOD_EVENT, 16'h001f);
      settle(7'h04);
      chk("summary", 16'h0000, parentSummary);
      rd(SEL_MOD_EVENT, 16'h0000);
      op(1'b1, SEL_MOD_FALL, 16'h0010);
      settle(7'h00);
      chk("summary", 16'h0080, parentSummary);
      rd(SEL_MOD_EVENT, 16'h0010);
      $display("t_mod done");
   endtask
   task automatic t_cal();
      op(1'b1, SEL_CAL_RISE, 16'h0001);
      op(1'b1, SEL_CAL_FALL, 16'h0000);
      op(1'b1, SEL_CAL_MASK, 16'h0002);
      settle(7'h02);
      rd(SEL_CAL_COND, 16'h0001);
      settle(7'h01);
      op(1'b1, SEL_CAL_COND, 16'hffff);
      rd(SEL_CAL_COND, 16'h0002);
      chk("summary", 16'h0000, parentSummary);
      op(1'b1, SEL_CAL_MASK, 16'h0001);
      idle(1);
      chk("summary", 16'h0100, parentSummary);
      rd(SEL_CAL_EVENT, 16'h0001);
      rd(SEL_CAL_EVENT, 16'h0000);
      $display("t_cal done");
   endtask
   task automatic summarize();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      rst_n = 1'b0;
      status = '0;
      req = '0;
      failures = 0;
      n_compared = 0;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      t_regs();
      t_mod();
      t_cal();
      summarize();
   end
endmodule

bind qmcs_top qmcs_monitor i_qmcs_monitor (.clk(clk), .rst_n(rst_n),
   .status(status), .req(req), .rdata(rdata), .rdValid(rdValid),
   .parentSummary(parentSummary));
